//--- logic/status_reporting_bits.sv
`timescale 1ns/100ps

module status_reporting_bits (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire status_pkg::normal_cond_t      normal_cond,
  input  wire status_pkg::abnormal_cond_t    abnormal_cond,
  input  wire status_pkg::std_event_pulses_t std_events,
  input  wire logic                          msg_queue_nonempty,
  input  wire status_pkg::status_cmd_t       cmd,
  input  wire logic                          serial_poll,
  output status_pkg::status_rsp_t            rsp,
  output status_pkg::poll_rsp_t              poll_rsp,
  output logic                               srq
);

  ////////////////////////////////////////////////////////////////////////////
  // Mapping helpers

  function automatic logic [status_pkg::GROUP_W-1:0] normal_vector(
    input status_pkg::normal_cond_t c
  );
    logic [status_pkg::GROUP_W-1:0] v;
    v = status_pkg::GROUP_ZERO;
    v[status_pkg::NRM_CALIBRATING_BIT]   = c.calibrating;
    v[status_pkg::NRM_AWAIT_TRIGGER_BIT] = c.awaiting_trigger;
    v[status_pkg::NRM_VOLTAGE_REG_BIT]   = c.voltage_regulation;
    v[status_pkg::NRM_CURRENT_POS_BIT]   = c.current_regulation_pos;
    v[status_pkg::NRM_CURRENT_NEG_BIT]   = c.current_regulation_neg;
    return v;
  endfunction

  function automatic logic [status_pkg::GROUP_W-1:0] abnormal_vector(
    input status_pkg::abnormal_cond_t c
  );
    logic [status_pkg::GROUP_W-1:0] v;
    v = status_pkg::GROUP_ZERO;
    v[status_pkg::ABN_VOLTAGE_TRIP_BIT] = c.voltage_limit_trip;
    v[status_pkg::ABN_CURRENT_TRIP_BIT] = c.current_limit_trip;
    v[status_pkg::ABN_THERMAL_TRIP_BIT] = c.thermal_trip;
    v[status_pkg::ABN_FUSE_OPEN_BIT]    = c.fuse_open;
    v[status_pkg::ABN_INHIBIT_BIT]      = c.remote_inhibit;
    v[status_pkg::ABN_UNREGULATED_BIT]  = c.unregulated;
    v[status_pkg::ABN_METER_OVLD_BIT]   = c.meter_range_overload;
    return v;
  endfunction

  function automatic logic [status_pkg::BYTE_W-1:0] std_vector(
    input status_pkg::std_event_pulses_t e,
    input logic                          power_on
  );
    logic [status_pkg::BYTE_W-1:0] v;
    v = status_pkg::BYTE_ZERO;
    v[status_pkg::STD_OP_COMPLETE_BIT] = e.op_complete;
    v[status_pkg::STD_QUERY_ERR_BIT]   = e.query_error;
    v[status_pkg::STD_DEVICE_ERR_BIT]  = e.device_error;
    v[status_pkg::STD_EXEC_ERR_BIT]    = e.exec_error;
    v[status_pkg::STD_CMD_ERR_BIT]     = e.command_error;
    v[status_pkg::STD_POWER_ON_BIT]    = power_on;
    return v;
  endfunction

  // Status byte; bit 6 is supplied by the caller (zero here, overlaid later by with_service)
  function automatic logic [status_pkg::BYTE_W-1:0] status_byte(
    input logic normal_sum,
    input logic abnormal_sum,
    input logic std_sum,
    input logic msg_avail,
    input logic service_bit
  );
    logic [status_pkg::BYTE_W-1:0] v;
    v = status_pkg::BYTE_ZERO;
    v[status_pkg::SB_ABNORMAL_BIT]  = abnormal_sum;
    v[status_pkg::SB_MSG_AVAIL_BIT] = msg_avail;
    v[status_pkg::SB_STD_EVENT_BIT] = std_sum;
    v[status_pkg::SB_SERVICE_BIT]   = service_bit;
    v[status_pkg::SB_NORMAL_BIT]    = normal_sum;
    return v;
  endfunction

  // Overlays the service bit on a byte built without it
  function automatic logic [status_pkg::BYTE_W-1:0] with_service(
    input logic [status_pkg::BYTE_W-1:0] base,
    input logic                          flag
  );
    logic [status_pkg::BYTE_W-1:0] v;
    v                             = base;
    v[status_pkg::SB_SERVICE_BIT] = flag;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Two-flop synchronisers for the analog levels
    logic [status_pkg::GROUP_W-1:0] normal_s1;
    logic [status_pkg::GROUP_W-1:0] normal_s2;
    logic [status_pkg::GROUP_W-1:0] abnormal_s1;
    logic [status_pkg::GROUP_W-1:0] abnormal_s2;
    logic [status_pkg::BYTE_W-1:0]  std_event;
    logic [status_pkg::BYTE_W-1:0]  std_enable;
    logic [status_pkg::BYTE_W-1:0]  service_mask;
    logic                           msg_avail;
    logic                           pon_pending;
    logic                           mss_prev;
    logic                           rqs;

    // Answers are registered so every output leaves a flop
    status_pkg::status_rsp_t        rsp;
    status_pkg::poll_rsp_t          poll;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  logic [status_pkg::GROUP_W-1:0] normal_rd;
  logic [status_pkg::GROUP_W-1:0] abnormal_rd;
  logic                           normal_sum;
  logic                           abnormal_sum;
  logic                           std_sum;
  logic                           mss;
  logic [status_pkg::BYTE_W-1:0]  stb_no_service;
  logic [status_pkg::BYTE_W-1:0]  service_bit_mask;
  logic                           cmd_rd;
  logic                           cmd_wr;
  logic                           std_clear;
  logic                           normal_sel;
  logic                           abnormal_sel;
  logic                           rqs_set;
  logic                           rqs_clr;
  logic [status_pkg::BYTE_W-1:0]  std_set;
  logic [status_pkg::BYTE_W-1:0]  live_stb;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  always_comb begin
    normal_sel   = cmd.grp == status_pkg::GRP_NORMAL;
    abnormal_sel = cmd.grp == status_pkg::GRP_ABNORMAL;

    cmd_rd       = cmd.valid && !cmd.write;
    cmd_wr       = cmd.valid && cmd.write;
    // Clear-all reaches every group whichever group it names
    std_clear    = (cmd_rd && cmd.grp == status_pkg::GRP_STANDARD &&
                    cmd.fld == status_pkg::FLD_EVENT) ||
                   (cmd.valid && cmd.fld == status_pkg::FLD_CLEAR_ALL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition groups, fed only from the second synchroniser stage

  status_group u_normal (
    .clk      (clk),
    .nrst     (nrst),
    .cond     (q.normal_s2),
    .cmd      (cmd),
    .selected (normal_sel),
    .rd_value (normal_rd),
    .summary  (normal_sum)
  );

  status_group u_abnormal (
    .clk      (clk),
    .nrst     (nrst),
    .cond     (q.abnormal_s2),
    .cmd      (cmd),
    .selected (abnormal_sel),
    .rd_value (abnormal_rd),
    .summary  (abnormal_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Summaries

  always_comb begin
    service_bit_mask = status_pkg::BYTE_ZERO;
    service_bit_mask[status_pkg::SB_SERVICE_BIT] = 1'b1;

    // No filters here: the pulses are already events
    std_sum        = |(q.std_event & q.std_enable);
    stb_no_service = status_byte(normal_sum, abnormal_sum, std_sum,
                                 q.msg_avail, 1'b0);
    // Unlatched, so it drops as soon as its causes are cleared
    mss = |(stb_no_service & q.service_mask & ~service_bit_mask);
    live_stb       = with_service(stb_no_service, mss);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d         = q;

    // Analog conditions are asynchronous to clk
    d.normal_s1   = normal_vector(normal_cond);
    d.normal_s2   = q.normal_s1;
    d.abnormal_s1 = abnormal_vector(abnormal_cond);
    d.abnormal_s2 = q.abnormal_s1;

    // Same-clock level, seen one cycle late
    d.msg_avail   = msg_queue_nonempty;
    // Power-on event is offered once per reset release
    d.pon_pending = 1'b0;
    std_set       = std_vector(std_events, q.pon_pending);
    // New events win over a clear in the same cycle
    d.std_event   = (q.std_event & ~{status_pkg::BYTE_W{std_clear}}) | std_set;

    if (cmd_wr && cmd.fld == status_pkg::FLD_ENABLE) begin
      case (cmd.grp)
        status_pkg::GRP_STANDARD: begin
          d.std_enable = cmd.data[status_pkg::BYTE_W-1:0];
        end
        status_pkg::GRP_SUMMARY: begin
          // Bit 6 of the mask has no meaning and always reads zero
          d.service_mask = cmd.data[status_pkg::BYTE_W-1:0] & ~service_bit_mask;
        end
        default: ;
      endcase
    end

    // Request flag: latch on a new reason, only a poll clears it
    d.mss_prev = mss;
    rqs_set    = mss && !q.mss_prev;
    rqs_clr    = serial_poll;
    // Set wins, so a reason born in the poll cycle is kept
    d.rqs      = (q.rqs && !rqs_clr) || rqs_set;

    // Poll answer carries the latched flag, not the live summary
    d.poll.valid = serial_poll;
    if (serial_poll) begin
      d.poll.stb = with_service(stb_no_service, q.rqs);
    end else begin
      d.poll.stb = status_pkg::BYTE_ZERO;
    end

    // Read answer; data stays zero outside a valid answer
    d.rsp.valid   = cmd_rd;
    d.rsp.refused = 1'b0;
    d.rsp.data    = status_pkg::GROUP_ZERO;
    if (cmd_rd) begin
      case (cmd.grp)
        status_pkg::GRP_NORMAL: begin
          d.rsp.data = normal_rd;
        end
        status_pkg::GRP_ABNORMAL: begin
          d.rsp.data = abnormal_rd;
        end
        status_pkg::GRP_STANDARD: begin
          case (cmd.fld)
            status_pkg::FLD_EVENT: begin
              d.rsp.data[status_pkg::BYTE_W-1:0] = q.std_event;
            end
            status_pkg::FLD_ENABLE: begin
              d.rsp.data[status_pkg::BYTE_W-1:0] = q.std_enable;
            end
            default: begin
              d.rsp.refused = 1'b1;
            end
          endcase
        end
        status_pkg::GRP_SUMMARY: begin
          case (cmd.fld)
            status_pkg::FLD_CONDITION: begin
              // Query form shows the live summary, never clears
              d.rsp.data[status_pkg::BYTE_W-1:0] = live_stb;
            end
            status_pkg::FLD_ENABLE: begin
              d.rsp.data[status_pkg::BYTE_W-1:0] = q.service_mask;
            end
            default: begin
              d.rsp.refused = 1'b1;
            end
          endcase
        end
        default: begin
          d.rsp.refused = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Synchronisers
      q.normal_s1     <= status_pkg::GROUP_ZERO;
      q.normal_s2     <= status_pkg::GROUP_ZERO;
      q.abnormal_s1   <= status_pkg::GROUP_ZERO;
      q.abnormal_s2   <= status_pkg::GROUP_ZERO;

      // Status and request registers
      q.std_event     <= status_pkg::BYTE_ZERO;
      q.std_enable    <= status_pkg::BYTE_ZERO;
      q.service_mask  <= status_pkg::BYTE_ZERO;
      q.msg_avail     <= 1'b0;
      q.pon_pending   <= 1'b1;
      q.mss_prev      <= 1'b0;
      q.rqs           <= 1'b0;

      // Answers
      q.rsp.valid     <= 1'b0;
      q.rsp.refused   <= 1'b0;
      q.rsp.data      <= status_pkg::GROUP_ZERO;
      q.poll.valid    <= 1'b0;
      q.poll.stb      <= status_pkg::BYTE_ZERO;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rsp      = q.rsp;
  assign poll_rsp = q.poll;
  assign srq      = q.rqs;

endmodule

//--- logic/status_pkg.sv
package status_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int GROUP_W = 16;
  localparam int BYTE_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Normal-operation group bit positions
  localparam int NRM_CALIBRATING_BIT   = 0;
  localparam int NRM_AWAIT_TRIGGER_BIT = 5;
  localparam int NRM_VOLTAGE_REG_BIT   = 8;
  localparam int NRM_CURRENT_POS_BIT   = 10;
  localparam int NRM_CURRENT_NEG_BIT   = 11;

  // Abnormal-operation group bit positions
  localparam int ABN_VOLTAGE_TRIP_BIT  = 0;
  localparam int ABN_CURRENT_TRIP_BIT  = 1;
  localparam int ABN_FUSE_OPEN_BIT     = 2;
  localparam int ABN_THERMAL_TRIP_BIT  = 4;
  localparam int ABN_INHIBIT_BIT       = 9;
  localparam int ABN_UNREGULATED_BIT   = 10;
  localparam int ABN_METER_OVLD_BIT    = 14;

  // Standard event bit positions
  localparam int STD_OP_COMPLETE_BIT   = 0;
  localparam int STD_QUERY_ERR_BIT     = 2;
  localparam int STD_DEVICE_ERR_BIT    = 3;
  localparam int STD_EXEC_ERR_BIT      = 4;
  localparam int STD_CMD_ERR_BIT       = 5;
  localparam int STD_POWER_ON_BIT      = 7;

  // Status byte and service request mask bit positions
  localparam int SB_ABNORMAL_BIT       = 3;
  localparam int SB_MSG_AVAIL_BIT      = 4;
  localparam int SB_STD_EVENT_BIT      = 5;
  localparam int SB_SERVICE_BIT        = 6;
  localparam int SB_NORMAL_BIT         = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and preset values
  localparam logic [GROUP_W-1:0] RISING_RESET     = 16'hFFFF;
  localparam logic [GROUP_W-1:0] FALLING_RESET    = 16'h0000;
  localparam logic [GROUP_W-1:0] GROUP_EN_RESET   = 16'h0000;
  localparam logic [GROUP_W-1:0] GROUP_ZERO       = 16'h0000;
  localparam logic [BYTE_W-1:0]  BYTE_ZERO        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Command port
  typedef enum logic [1:0] {
    GRP_NORMAL,
    GRP_ABNORMAL,
    GRP_STANDARD,
    GRP_SUMMARY
  } group_sel_t;

  typedef enum logic [2:0] {
    FLD_CONDITION,
    FLD_RISING,
    FLD_FALLING,
    FLD_EVENT,
    FLD_ENABLE,
    FLD_CLEAR_ALL,
    FLD_PRESET
  } field_sel_t;

  typedef struct packed {
    logic               valid;
    logic               write;
    group_sel_t         grp;
    field_sel_t         fld;
    logic [GROUP_W-1:0] data;
  } status_cmd_t;

  typedef struct packed {
    logic               valid;
    logic               refused;
    logic [GROUP_W-1:0] data;
  } status_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [BYTE_W-1:0] stb;
  } poll_rsp_t;

  ////////////////////////////////////////////////////////////////////////////
  // Condition and event carriers
  typedef struct packed {
    logic calibrating;
    logic awaiting_trigger;
    logic voltage_regulation;
    logic current_regulation_pos;
    logic current_regulation_neg;
  } normal_cond_t;

  typedef struct packed {
    logic voltage_limit_trip;
    logic current_limit_trip;
    logic fuse_open;
    logic thermal_trip;
    logic remote_inhibit;
    logic unregulated;
    logic meter_range_overload;
  } abnormal_cond_t;

  typedef struct packed {
    logic op_complete;
    logic query_error;
    logic device_error;
    logic exec_error;
    logic command_error;
  } std_event_pulses_t;

endpackage

//--- logic/status_group.sv
`timescale 1ns/100ps

module status_group (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [status_pkg::GROUP_W-1:0] cond,
  input  wire status_pkg::status_cmd_t      cmd,
  input  wire logic                         selected,
  output logic      [status_pkg::GROUP_W-1:0] rd_value,
  output logic                              summary
);

  typedef struct packed {
    logic [status_pkg::GROUP_W-1:0] cond_prev;
    logic [status_pkg::GROUP_W-1:0] rising;
    logic [status_pkg::GROUP_W-1:0] falling;
    logic [status_pkg::GROUP_W-1:0] event_bits;
    logic [status_pkg::GROUP_W-1:0] enable;
  } group_state_t;

  group_state_t q;
  group_state_t d;
  logic         hit_rd;
  logic         hit_wr;
  logic         clear;
  logic [status_pkg::GROUP_W-1:0] caught;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d      = q;
    hit_rd = cmd.valid && selected && !cmd.write;
    hit_wr = cmd.valid && selected && cmd.write;
    d.cond_prev = cond;
    if (hit_wr) begin
      case (cmd.fld)
        status_pkg::FLD_RISING:  d.rising  = cmd.data;
        status_pkg::FLD_FALLING: d.falling = cmd.data;
        status_pkg::FLD_ENABLE:  d.enable  = cmd.data;
        default: ;
      endcase
    end
    // Preset restores the filters and mask but keeps latched events
    if (cmd.valid && cmd.fld == status_pkg::FLD_PRESET) begin
      d.rising  = status_pkg::RISING_RESET;
      d.falling = status_pkg::FALLING_RESET;
      d.enable  = status_pkg::GROUP_EN_RESET;
    end
    clear  = (hit_rd && cmd.fld == status_pkg::FLD_EVENT) ||
             (cmd.valid && cmd.fld == status_pkg::FLD_CLEAR_ALL);
    caught = (cond & ~q.cond_prev & q.rising) | (~cond & q.cond_prev & q.falling);
    // A transition seen in the clearing cycle survives the clear
    d.event_bits = (q.event_bits & ~{status_pkg::GROUP_W{clear}}) | caught;
  end

  always_comb begin
    case (cmd.fld)
      status_pkg::FLD_CONDITION: rd_value = cond;
      status_pkg::FLD_RISING:    rd_value = q.rising;
      status_pkg::FLD_FALLING:   rd_value = q.falling;
      status_pkg::FLD_EVENT:     rd_value = q.event_bits;
      status_pkg::FLD_ENABLE:    rd_value = q.enable;
      default:                   rd_value = status_pkg::GROUP_ZERO;
    endcase
  end

  assign summary = |(q.event_bits & q.enable);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q.cond_prev  <= status_pkg::GROUP_ZERO;
      q.rising     <= status_pkg::RISING_RESET;
      q.falling    <= status_pkg::FALLING_RESET;
      q.event_bits <= status_pkg::GROUP_ZERO;
      q.enable     <= status_pkg::GROUP_EN_RESET;
    end else begin
      q <= d;
    end
  end

endmodule

//--- testbench/status_reporting_bits_sva.sv
`timescale 1ns/100ps
module status_reporting_bits_sva (
  input wire logic                          clk,
  input wire logic                          nrst,
  input wire status_pkg::normal_cond_t      normal_cond,
  input wire status_pkg::abnormal_cond_t    abnormal_cond,
  input wire status_pkg::std_event_pulses_t std_events,
  input wire logic                          msg_queue_nonempty,
  input wire status_pkg::status_cmd_t       cmd,
  input wire logic                          serial_poll,
  input wire status_pkg::status_rsp_t       rsp,
  input wire status_pkg::poll_rsp_t         poll_rsp,
  input wire logic                          srq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd;
  logic sum_rd;
  assign rd = cmd.valid && !cmd.write;
  assign sum_rd = rd && cmd.grp == status_pkg::GRP_SUMMARY;
  ////////////////////////////////////////////////////////////
  property p_poll_ans;
    serial_poll |=> poll_rsp.valid;
  endproperty
  a_poll_ans: assert property (p_poll_ans) else $error("poll answer missing");
  property p_poll_flag;
    serial_poll |=> poll_rsp.stb[6] == $past(srq);
  endproperty
  a_poll_flag: assert property (p_poll_flag) else $error("poll bit 6 wrong");
  property p_srq_hold;
    srq && !serial_poll |=> srq;
  endproperty
  a_srq_hold: assert property (p_srq_hold) else $error("srq dropped without poll");
  property p_rsp_ans;
    rd && (cmd.fld == status_pkg::FLD_ENABLE ||
           cmd.fld == status_pkg::FLD_EVENT && !sum_rd) |=> rsp.valid && !rsp.refused;
  endproperty
  a_rsp_ans: assert property (p_rsp_ans) else $error("read answer missing");
  property p_idle_zero;
    !rsp.valid |-> rsp.data == 16'h0000 && !rsp.refused;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle response not zero");
  property p_sb_zero;
    sum_rd |=> rsp.data[15:8] == 8'h00 && rsp.data[2:0] == 3'h0;
  endproperty
  a_sb_zero: assert property (p_sb_zero) else $error("status byte unused bits set");
  // Bit 4 lags the queue flag, so only a steady flag is judged
  property p_mav;
    $stable(msg_queue_nonempty)[*2] ##0 sum_rd && cmd.fld == status_pkg::FLD_CONDITION
      |=> rsp.data[4] == $past(msg_queue_nonempty);
  endproperty
  a_mav: assert property (p_mav) else $error("message available bit wrong");
  property p_refused;
    rd && cmd.grp == status_pkg::GRP_STANDARD && cmd.fld == status_pkg::FLD_RISING
      |=> rsp.valid && rsp.refused && rsp.data == 16'h0000;
  endproperty
  a_refused: assert property (p_refused) else $error("undefined read not refused");
  property p_mask6;
    sum_rd && cmd.fld == status_pkg::FLD_ENABLE |=> rsp.data[6] == 1'b0;
  endproperty
  a_mask6: assert property (p_mask6) else $error("mask bit 6 set");
endmodule

bind status_reporting_bits status_reporting_bits_sva chk (
  .clk(clk), .nrst(nrst), .normal_cond(normal_cond), .abnormal_cond(abnormal_cond),
  .std_events(std_events), .msg_queue_nonempty(msg_queue_nonempty), .cmd(cmd),
  .serial_poll(serial_poll), .rsp(rsp), .poll_rsp(poll_rsp), .srq(srq)
);

//--- testbench/host_poll_model.sv
`timescale 1ns/100ps
// Bus controller that answers every service request with one serial poll
module host_poll_model (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  srq,
  input wire status_pkg::poll_rsp_t poll_rsp,
  output logic                      serial_poll,
  output logic [7:0]                last_stb,
  output int                        polls
);
  initial begin
    serial_poll = 1'b0;
    last_stb = 8'h00;
    polls = 0;
    forever begin
      @(negedge clk);
      if (nrst === 1'b1 && srq === 1'b1) begin
        serial_poll <= 1'b1;
        @(negedge clk);
        serial_poll <= 1'b0;
        // Bounded wait; a stale byte is caught by the checker
        for (int n = 0; n < 3 && poll_rsp.valid !== 1'b1; n++) @(negedge clk);
        last_stb <= poll_rsp.stb;
        polls <= polls + 1;
      end
    end
  end
endmodule

//--- testbench/test_status_reporting_bits.sv
`timescale 1ns/100ps
module test_status_reporting_bits;
  logic                          clk;
  logic                          nrst;
  status_pkg::normal_cond_t      normal_cond;
  status_pkg::abnormal_cond_t    abnormal_cond;
  status_pkg::std_event_pulses_t std_events;
  logic                          msg_queue_nonempty;
  status_pkg::status_cmd_t       cmd;
  logic                          serial_poll;
  status_pkg::status_rsp_t       rsp;
  status_pkg::poll_rsp_t         poll_rsp;
  logic                          srq;
  logic [7:0]                    last_stb;
  int                            polls;
  int                            p0;
  int                            err_total;
  int                            check_count;
  logic [15:0]                   rd_val;
  status_pkg::status_rsp_t       got;
  status_pkg::group_sel_t        g;
  localparam int CB [12] = '{0, 5, 8, 10, 11, 0, 1, 2, 4, 9, 10, 14};
  localparam int EB [5] = '{0, 2, 3, 4, 5};
  localparam int SB [4] = '{3, 7, 5, 4};

  status_reporting_bits dut (.clk(clk), .nrst(nrst), .normal_cond(normal_cond),
    .abnormal_cond(abnormal_cond), .std_events(std_events),
    .msg_queue_nonempty(msg_queue_nonempty), .cmd(cmd), .serial_poll(serial_poll),
    .rsp(rsp), .poll_rsp(poll_rsp), .srq(srq));
  host_poll_model host (.clk(clk), .nrst(nrst), .srq(srq), .poll_rsp(poll_rsp),
    .serial_poll(serial_poll), .last_stb(last_stb), .polls(polls));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic w, input status_pkg::group_sel_t gs,
                      input status_pkg::field_sel_t f, input logic [15:0] d);
    int n;
    @(negedge clk);
    cmd <= {1'b1, w, gs, f, d};
    @(negedge clk);
    cmd <= {1'b0, w, gs, f, d};
    n = 0;
    while (!w && rsp.valid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    got = rsp;
    rd_val = rsp.valid === 1'b1 ? rsp.data : 16'hXXXX;
  endtask
  task automatic rd(input status_pkg::group_sel_t gs, input status_pkg::field_sel_t f,
                    input logic [15:0] exp);
    send(1'b0, gs, f, 16'h0000);
    chk(rd_val, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    {nrst, normal_cond, abnormal_cond, std_events, msg_queue_nonempty, cmd} = '0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(status_pkg::GRP_NORMAL, status_pkg::FLD_RISING, 16'hFFFF);
    rd(status_pkg::GRP_ABNORMAL, status_pkg::FLD_FALLING, 16'h0000);
    rd(status_pkg::GRP_SUMMARY, status_pkg::FLD_ENABLE, 16'h0000);
    rd(status_pkg::GRP_STANDARD, status_pkg::FLD_EVENT, 16'h0080);
    rd(status_pkg::GRP_STANDARD, status_pkg::FLD_EVENT, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      std_events <= 5'h10 >> i;
      @(negedge clk);
      std_events <= '0;
      rd(status_pkg::GRP_STANDARD, status_pkg::FLD_EVENT, 16'h1 << EB[i]);
    end
    send(1'b0, status_pkg::GRP_STANDARD, status_pkg::FLD_RISING, 16'h0000);
    chk({15'h0000, got.refused}, 16'h0001);
    send(1'b1, status_pkg::GRP_NORMAL, status_pkg::FLD_CONDITION, 16'hFFFF);
    rd(status_pkg::GRP_NORMAL, status_pkg::FLD_CONDITION, 16'h0000);
    // One condition at a time: level, rising event, no falling event
    for (int i = 0; i < 12; i++) begin
      g = i < 5 ? status_pkg::GRP_NORMAL : status_pkg::GRP_ABNORMAL;
      normal_cond <= i < 5 ? 5'h10 >> i : 5'h00;
      abnormal_cond <= i < 5 ? 7'h00 : 7'h40 >> (i - 5);
      repeat (5) @(negedge clk);
      rd(g, status_pkg::FLD_CONDITION, 16'h1 << CB[i]);
      rd(g, status_pkg::FLD_EVENT, 16'h1 << CB[i]);
      normal_cond <= '0;
      abnormal_cond <= '0;
      repeat (5) @(negedge clk);
      rd(g, status_pkg::FLD_EVENT, 16'h0000);
    end
    send(1'b1, status_pkg::GRP_NORMAL, status_pkg::FLD_RISING, 16'h0000);
    send(1'b1, status_pkg::GRP_NORMAL, status_pkg::FLD_FALLING, 16'h0100);
    normal_cond <= 5'h04;
    repeat (5) @(negedge clk);
    rd(status_pkg::GRP_NORMAL, status_pkg::FLD_EVENT, 16'h0000);
    normal_cond <= '0;
    repeat (5) @(negedge clk);
    rd(status_pkg::GRP_NORMAL, status_pkg::FLD_EVENT, 16'h0100);
    send(1'b1, status_pkg::GRP_ABNORMAL, status_pkg::FLD_PRESET, 16'h0000);
    rd(status_pkg::GRP_NORMAL, status_pkg::FLD_RISING, 16'hFFFF);
    // Each summary source in turn must reach the controller
    for (int k = 0; k < 4; k++) begin
      p0 = polls;
      send(1'b1, status_pkg::GRP_SUMMARY, status_pkg::FLD_ENABLE, 16'h1 << SB[k]);
      case (k)
        0: begin
          send(1'b1, status_pkg::GRP_ABNORMAL, status_pkg::FLD_ENABLE, 16'h0002);
          abnormal_cond <= 7'h20;
        end
        1: begin
          send(1'b1, status_pkg::GRP_NORMAL, status_pkg::FLD_ENABLE, 16'h0400);
          normal_cond <= 5'h02;
        end
        2: begin
          send(1'b1, status_pkg::GRP_STANDARD, status_pkg::FLD_ENABLE, 16'h0001);
          std_events <= 5'h10;
          @(negedge clk);
          std_events <= '0;
        end
        default: msg_queue_nonempty <= 1'b1;
      endcase
      repeat (10) @(negedge clk);
      chk(16'(polls - p0), 16'h0001);
      chk({8'h00, last_stb}, 16'h0040 | (16'h1 << SB[k]));
      rd(status_pkg::GRP_SUMMARY, status_pkg::FLD_CONDITION, 16'h0040 | (16'h1 << SB[k]));
      chk({15'h0000, srq}, 16'h0000);
      send(1'b1, status_pkg::GRP_SUMMARY, status_pkg::FLD_ENABLE, 16'h0000);
      normal_cond <= '0;
      abnormal_cond <= '0;
      msg_queue_nonempty <= 1'b0;
      send(1'b1, status_pkg::GRP_STANDARD, status_pkg::FLD_ENABLE, 16'h0000);
      send(1'b1, status_pkg::GRP_NORMAL, status_pkg::FLD_PRESET, 16'h0000);
      repeat (5) @(negedge clk);
      send(1'b1, status_pkg::GRP_SUMMARY, status_pkg::FLD_CLEAR_ALL, 16'h0000);
      rd(status_pkg::GRP_ABNORMAL, status_pkg::FLD_EVENT, 16'h0000);
      rd(status_pkg::GRP_STANDARD, status_pkg::FLD_EVENT, 16'h0000);
    end
    conclude();
  end
endmodule
